/* File: include/sdc_pkg.sv */
// shared constants and types for the stepper drive control front end
package sdc_pkg;
  localparam int FRAME_BITS = 20;
  localparam int POS_BITS = 10;
  // register select field in bits 19..17
  localparam int SEL_HI = 19;
  localparam int SEL_LO = 17;
  localparam logic [1:0] SEL_DRIVE_CONTROL = 2'h0;
  localparam logic [2:0] SEL_DRIVER_CONFIG = 3'h7;
  // driver configuration fields
  localparam int CFG_SD_DISABLE_BIT = 7;
  localparam int CFG_RSEL_HI = 5;
  localparam int CFG_RSEL_LO = 4;
  // drive control fields, direct mode
  localparam int DC_DIR_A_BIT = 17;
  localparam int DC_MAG_A_HI = 16;
  localparam int DC_MAG_A_LO = 9;
  localparam int DC_DIR_B_BIT = 8;
  localparam int DC_MAG_B_HI = 7;
  localparam int DC_MAG_B_LO = 0;
  // drive control fields, step/dir mode
  localparam int DC_INTERP_BIT = 9;
  localparam int DC_DUAL_EDGE_BIT = 8;
  localparam int DC_RES_HI = 3;
  localparam int DC_RES_LO = 0;
  localparam logic [3:0] RES_CODE_FULL = 4'h8;
  localparam logic [4:0] INTERP_FACTOR = 5'h10;
  localparam logic [3:0] INTERP_SHIFT = 4'h4;
  // response select codes
  localparam logic [1:0] RSEL_POSITION = 2'h0;
  localparam logic [1:0] RSEL_LOAD = 2'h1;
  localparam logic [1:0] RSEL_LOAD_SCALE = 2'h2;
  localparam logic [1:0] RSEL_DIAG = 2'h3;
  // reset values
  localparam logic [19:0] DRIVE_CONTROL_RST = 20'h0_0000;
  localparam logic [19:0] DRIVER_CONFIG_RST = 20'h0_0000;
  localparam logic [9:0] POS_RST = 10'h000;

  // status flags reported in the low response byte
  typedef struct packed {
    logic standstill_flag;
    logic open_load_coil_b;
    logic open_load_coil_a;
    logic ground_fault_coil_b;
    logic ground_fault_coil_a;
    logic supply_fault_coil_b;
    logic supply_fault_coil_a;
    logic overtemp_prewarning;
    logic overtemp_shutdown;
    logic stall_flag;
  } sdc_status_s;

  // extra diagnostics for the enhanced variant
  typedef struct packed {
    logic undervoltage_flag;
    logic driver_enable_input_low;
    logic temp_flag_highest;
    logic temp_flag_high;
    logic temp_flag_mid;
    logic temp_flag_low;
  } sdc_diag_s;

  // coil drive target
  typedef struct packed {
    logic coil_a_direction;
    logic [7:0] coil_a_magnitude;
    logic coil_b_direction;
    logic [7:0] coil_b_magnitude;
  } sdc_coil_s;
endpackage

/* File: design/sdc_top.sv */
// serial front end of the stepper driver: register decode, response and step/dir position
//
// How it works
// - two-bit select picks one of four responses
// - position, load, load plus scale, or diagnostics above
// - low byte carries eight status flags
// - basic variant short flags mean ground faults
// - mode bit picks drive control format
// - direct mode ignores step/dir, uses register currents
// - step/dir mode uses register as config
// - bit 17 sets coil A direction
// - bit 8 sets coil B direction
// - bits 16..9 give coil A magnitude
// - bits 7..0 give coil B magnitude
// - bit 9 enables sixteenfold step interpolation at 16 microsteps or fewer
// - bit 8 makes both step edges active
// - bits 3..0 set microsteps, 256 down to 1
// - bits 19..18 zero address drive control
// - only last 20 bits before deselect load
`timescale 1ns/1ps
`default_nettype none
module sdc_top #(
  parameter bit ENHANCED = 1'b1,
  parameter int TICK_CYCLES = 4
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic spi_clk,
  input wire logic spi_data_in,
  input wire logic chip_select_low,
  output logic spi_data_out,
  output logic spi_data_oe,
  input wire logic step_in,
  input wire logic dir_in,
  input wire logic [9:0] load_measure,
  input wire logic [4:0] current_scale_value,
  input wire sdc_pkg::sdc_status_s status_in,
  input wire sdc_pkg::sdc_diag_s diag_in,
  output sdc_pkg::sdc_coil_s coil_out,
  output logic [9:0] microstep_position,
  output logic step_dir_disable
);
  import sdc_pkg::*;

  // two-flop synchronisers for the serial and step/dir pins
  logic [4:0] sync1_ff, sync2_ff, prev_ff;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync1_ff <= 5'h1_0;
      sync2_ff <= 5'h1_0;
      prev_ff <= 5'h1_0;
    end else begin
      sync1_ff <= {chip_select_low, spi_clk, spi_data_in, step_in, dir_in};
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
    end
  end

  logic cs_n, sck_rise, sck_fall, cs_fall, cs_rise, sdi, step_rise, step_fall, dir_s;
  // edges found only on the second stage and its delayed copy
  assign cs_n = sync2_ff[4];
  assign cs_fall = prev_ff[4] & ~sync2_ff[4];
  assign cs_rise = ~prev_ff[4] & sync2_ff[4];
  assign sck_rise = ~prev_ff[3] & sync2_ff[3] & ~cs_n;
  assign sck_fall = prev_ff[3] & ~sync2_ff[3] & ~cs_n;
  assign sdi = sync2_ff[2];
  assign step_rise = ~prev_ff[1] & sync2_ff[1];
  assign step_fall = prev_ff[1] & ~sync2_ff[1];
  assign dir_s = sync2_ff[0];

  // serial shift and register state
  logic [19:0] shift_ff, nxt_shift;
  logic [19:0] resp_ff, nxt_resp;
  logic [4:0] count_ff, nxt_count;
  logic [19:0] drive_control_ff, nxt_drive_control;
  logic [19:0] driver_config_ff, nxt_driver_config;
  logic [19:0] resp_word;
  logic [1:0] response_select;
  sdc_status_s st;
  logic short_a, short_b;

  assign response_select = driver_config_ff[CFG_RSEL_HI:CFG_RSEL_LO];
  assign step_dir_disable = driver_config_ff[CFG_SD_DISABLE_BIT];
  assign st = status_in;
  // the enhanced part folds supply shorts in; the basic part reports ground shorts only
  assign short_a = st.ground_fault_coil_a | (ENHANCED & st.supply_fault_coil_a);
  assign short_b = st.ground_fault_coil_b | (ENHANCED & st.supply_fault_coil_b);

  // response layout chosen by the select field
  always_comb begin
    resp_word = 20'h0_0000;
    case (response_select)
      RSEL_POSITION: resp_word[19:10] = microstep_position;
      RSEL_LOAD: resp_word[19:10] = load_measure;
      RSEL_LOAD_SCALE: resp_word[19:10] = {load_measure[9:5], current_scale_value};
      RSEL_DIAG: begin
        if (ENHANCED) begin
          resp_word[19:8] = {diag_in.undervoltage_flag, diag_in.driver_enable_input_low,
            st.supply_fault_coil_b, st.ground_fault_coil_b, st.supply_fault_coil_a,
            st.ground_fault_coil_a, diag_in.temp_flag_highest, diag_in.temp_flag_high,
            diag_in.temp_flag_mid, diag_in.temp_flag_low, 2'b11};
        end
      end
      default: resp_word[19:10] = 10'h000;
    endcase
    resp_word[7:0] = {st.standstill_flag, st.open_load_coil_b, st.open_load_coil_a, short_b,
      short_a, st.overtemp_prewarning, st.overtemp_shutdown, st.stall_flag};
  end

  // frame shifter: response snapshot at select, load at deselect
  always_comb begin
    nxt_shift = shift_ff;
    nxt_resp = resp_ff;
    nxt_count = count_ff;
    nxt_drive_control = drive_control_ff;
    nxt_driver_config = driver_config_ff;
    if (cs_fall) begin
      nxt_resp = resp_word;
      nxt_count = 5'h0_0;
    end else if (sck_rise) begin
      // older bits fall off the top so long frames keep only the tail
      nxt_shift = {shift_ff[18:0], sdi};
      if (count_ff != 5'(FRAME_BITS)) begin
        nxt_count = count_ff + 5'h0_1;
      end
    end else if (sck_fall) begin
      nxt_resp = {resp_ff[18:0], 1'b0};
    end
    if (cs_rise && count_ff == 5'(FRAME_BITS)) begin
      if (shift_ff[SEL_HI:SEL_HI-1] == SEL_DRIVE_CONTROL) begin
        nxt_drive_control = shift_ff;
      end else if (shift_ff[SEL_HI:SEL_LO] == SEL_DRIVER_CONFIG) begin
        nxt_driver_config = shift_ff;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      shift_ff <= 20'h0_0000;
      resp_ff <= 20'h0_0000;
      count_ff <= 5'h0_0;
      drive_control_ff <= DRIVE_CONTROL_RST;
      driver_config_ff <= DRIVER_CONFIG_RST;
    end else begin
      shift_ff <= nxt_shift;
      resp_ff <= nxt_resp;
      count_ff <= nxt_count;
      drive_control_ff <= nxt_drive_control;
      driver_config_ff <= nxt_driver_config;
    end
  end

  // data out follows the response register; driven only while selected
  assign spi_data_out = resp_ff[19];
  assign spi_data_oe = ~cs_n;

  // step/dir configuration fields
  logic interp_en, dual_edge;
  logic [3:0] res_code;
  logic [9:0] step_size, sub_size;
  assign interp_en = drive_control_ff[DC_INTERP_BIT];
  assign dual_edge = drive_control_ff[DC_DUAL_EDGE_BIT];
  // codes above full step are undefined; clamp so the stride cannot overflow
  assign res_code = (drive_control_ff[DC_RES_HI:DC_RES_LO] > RES_CODE_FULL) ? RES_CODE_FULL
    : drive_control_ff[DC_RES_HI:DC_RES_LO];
  // each code step doubles the stride: 256 microsteps at 0, full step at 8
  assign step_size = 10'h001 << res_code;
  // below 1/16 resolution interpolation has nothing finer to add
  assign sub_size = (res_code >= INTERP_SHIFT) ? (step_size >> INTERP_SHIFT) : step_size;

  // tick divider paces the interpolated sub-steps
  logic [7:0] tick_ff, nxt_tick;
  logic tick;
  assign tick = (tick_ff == 8'(TICK_CYCLES - 1));
  always_comb begin
    nxt_tick = tick ? 8'h00 : tick_ff + 8'h01;
  end

  // position state
  logic [9:0] pos_ff, nxt_pos;
  logic [4:0] sub_left_ff, nxt_sub_left;
  logic sub_dir_ff, nxt_sub_dir;
  logic step_evt;
  assign step_evt = step_rise | (dual_edge & step_fall);

  always_comb begin
    nxt_pos = pos_ff;
    nxt_sub_left = sub_left_ff;
    nxt_sub_dir = sub_dir_ff;
    if (!step_dir_disable) begin
      if (step_evt) begin
        if (interp_en && res_code >= INTERP_SHIFT) begin
          // a new pulse restarts the burst; leftover sub-steps are dropped
          nxt_sub_left = INTERP_FACTOR;
          nxt_sub_dir = dir_s;
        end else begin
          nxt_pos = dir_s ? pos_ff - step_size : pos_ff + step_size;
        end
      end else if (tick && sub_left_ff != 5'h0_0) begin
        nxt_sub_left = sub_left_ff - 5'h0_1;
        nxt_pos = sub_dir_ff ? pos_ff - sub_size : pos_ff + sub_size;
      end
    end else begin
      // direct mode: step and direction pins have no effect
      nxt_sub_left = 5'h0_0;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      tick_ff <= 8'h00;
      pos_ff <= POS_RST;
      sub_left_ff <= 5'h0_0;
      sub_dir_ff <= 1'b0;
    end else begin
      tick_ff <= nxt_tick;
      pos_ff <= nxt_pos;
      sub_left_ff <= nxt_sub_left;
      sub_dir_ff <= nxt_sub_dir;
    end
  end
  assign microstep_position = pos_ff;

  // coil targets: register fields in direct mode, triangle of position otherwise
  sdc_coil_s coil_ff, nxt_coil;
  logic [7:0] tri_a, tri_b;
  assign tri_a = pos_ff[8] ? 8'hFF - pos_ff[7:0] : pos_ff[7:0];
  assign tri_b = pos_ff[8] ? pos_ff[7:0] : 8'hFF - pos_ff[7:0];
  always_comb begin
    if (step_dir_disable) begin
      nxt_coil.coil_a_direction = drive_control_ff[DC_DIR_A_BIT];
      nxt_coil.coil_a_magnitude = drive_control_ff[DC_MAG_A_HI:DC_MAG_A_LO];
      nxt_coil.coil_b_direction = drive_control_ff[DC_DIR_B_BIT];
      nxt_coil.coil_b_magnitude = drive_control_ff[DC_MAG_B_HI:DC_MAG_B_LO];
    end else begin
      nxt_coil.coil_a_direction = pos_ff[9];
      nxt_coil.coil_a_magnitude = tri_a;
      nxt_coil.coil_b_direction = pos_ff[9] ^ pos_ff[8];
      nxt_coil.coil_b_magnitude = tri_b;
    end
  end
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      coil_ff <= '0;
    end else begin
      coil_ff <= nxt_coil;
    end
  end
  assign coil_out = coil_ff;

  // checks
  a_resp_low_byte: assert property (@(posedge sys_clk) disable iff (sys_rst)
    cs_fall |=> resp_ff[7:0] == $past(resp_word[7:0]))
    else $error("response status byte wrong");
  a_resp_pos_sel: assert property (@(posedge sys_clk) disable iff (sys_rst)
    cs_fall && response_select == RSEL_POSITION |=> resp_ff[19:8] == {$past(pos_ff), 2'b00})
    else $error("position response wrong");
  a_resp_load_sel: assert property (@(posedge sys_clk) disable iff (sys_rst)
    cs_fall && response_select == RSEL_LOAD |=> resp_ff[19:8] == {$past(load_measure), 2'b00})
    else $error("load response wrong");
  a_resp_scale_sel: assert property (@(posedge sys_clk) disable iff (sys_rst)
    cs_fall && response_select == RSEL_LOAD_SCALE
    |=> resp_ff[14:8] == {$past(current_scale_value), 2'b00})
    else $error("load and scale response wrong");
  a_diag_ones: assert property (@(posedge sys_clk) disable iff (sys_rst)
    cs_fall && response_select == RSEL_DIAG && ENHANCED |=> resp_ff[9:8] == 2'b11)
    else $error("diagnostic marker bits not one");
  a_short_basic: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !ENHANCED |-> short_a == st.ground_fault_coil_a && short_b == st.ground_fault_coil_b)
    else $error("short flag not ground fault");
  a_load_full_frame: assert property (@(posedge sys_clk) disable iff (sys_rst)
    cs_rise && count_ff == 5'(FRAME_BITS) && shift_ff[19:18] == 2'b00
    |=> drive_control_ff == $past(shift_ff))
    else $error("drive control not loaded");
  a_cfg_mode: assert property (@(posedge sys_clk) disable iff (sys_rst)
    cs_rise && count_ff == 5'(FRAME_BITS) && shift_ff[SEL_HI:SEL_LO] == SEL_DRIVER_CONFIG
    |=> step_dir_disable == $past(shift_ff[CFG_SD_DISABLE_BIT]))
    else $error("mode bit not taken from configuration write");
  a_short_frame: assert property (@(posedge sys_clk) disable iff (sys_rst)
    cs_rise && count_ff != 5'(FRAME_BITS) |=> $stable(drive_control_ff) && $stable(driver_config_ff))
    else $error("short frame was loaded");
  a_direct_coil: assert property (@(posedge sys_clk) disable iff (sys_rst)
    step_dir_disable && $stable(drive_control_ff) && $stable(step_dir_disable)
    |=> coil_out == {$past(drive_control_ff[17:9]), $past(drive_control_ff[8:0])})
    else $error("direct coil currents wrong");
  a_direct_no_step: assert property (@(posedge sys_clk) disable iff (sys_rst)
    step_dir_disable && $past(step_dir_disable) |-> $stable(pos_ff))
    else $error("position moved in direct mode");
  // step edges, stride and interpolation
  a_single_edge: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !step_dir_disable && !dual_edge && step_fall && sub_left_ff == 5'h0_0 |=> $stable(pos_ff))
    else $error("falling step edge moved position");
  a_dual_fall: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !step_dir_disable && dual_edge && step_fall && !interp_en && res_code == RES_CODE_FULL && dir_s
    |=> pos_ff == $past(pos_ff) - 10'h100)
    else $error("falling step edge did not move position");
  a_full_step: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !step_dir_disable && step_rise && !interp_en && res_code == RES_CODE_FULL && !dir_s
    |=> pos_ff == $past(pos_ff) + 10'h100)
    else $error("full step stride wrong");
  a_interp_burst: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !step_dir_disable && step_evt && interp_en && res_code == INTERP_SHIFT |=> sub_left_ff == 5'h1_0)
    else $error("interpolation burst not sixteen sub-steps");
endmodule
`default_nettype wire

/* File: testbench/sdc_spi_host.sv */
// spi host model that frames register writes into the drive front end
`timescale 1ns/1ps
`default_nettype none
module sdc_spi_host (
  input wire logic sys_clk,
  output logic spi_clk,
  output logic spi_data_in,
  output logic chip_select_low,
  input wire logic spi_data_out
);
  // idle: serial clock parked low, frame deselected
  initial begin
    spi_clk = 1'b0;
    spi_data_in = 1'b0;
    chip_select_low = 1'b1;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // frame of nbits (at most 24), msb first, four phases of sys_clk per spi_clk level
  // callers pick the register in the top bits and keep reserved bits zero
  task automatic frame(input logic [23:0] tx, input int nbits, output logic [23:0] rx);
    cyc(1);
    chip_select_low = 1'b0;
    cyc(8);
    for (int i = nbits - 1; i >= 0; i--) begin
      spi_data_in = tx[i];
      cyc(4);
      spi_clk = 1'b1;
      rx[i] = spi_data_out;
      cyc(4);
      spi_clk = 1'b0;
    end
    cyc(4);
    chip_select_low = 1'b1;
    // released line shows the inverse so a stale bit cannot pass
    spi_data_in = ~spi_data_in;
    cyc(8);
  endtask
endmodule
`default_nettype wire

/* File: testbench/sdc_top_tb.sv */
// self-checking bench for the stepper drive front end
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin err_total++; \
  $display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module sdc_top_tb;
  import sdc_pkg::*;
  logic sys_clk, sys_rst, spi_clk, spi_data_in, chip_select_low, spi_data_out, spi_data_oe;
  logic step_in, dir_in, step_dir_disable;
  logic [9:0] load_measure, microstep_position, exp_pos;
  logic [4:0] current_scale_value;
  logic [23:0] rx;
  sdc_status_s status_in;
  sdc_diag_s diag_in;
  sdc_coil_s coil_out;
  int err_total, checks_done;

  sdc_top dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .spi_clk(spi_clk), .spi_data_in(spi_data_in),
    .chip_select_low(chip_select_low), .spi_data_out(spi_data_out), .spi_data_oe(spi_data_oe),
    .step_in(step_in), .dir_in(dir_in), .load_measure(load_measure),
    .current_scale_value(current_scale_value), .status_in(status_in), .diag_in(diag_in),
    .coil_out(coil_out), .microstep_position(microstep_position), .step_dir_disable(step_dir_disable));
  // undriven data line shows the inverse of its last bit, so a late enable is caught
  logic host_sdo;
  assign host_sdo = spi_data_oe ? spi_data_out : ~spi_data_out;
  sdc_spi_host host (.sys_clk(sys_clk), .spi_clk(spi_clk), .spi_data_in(spi_data_in),
    .chip_select_low(chip_select_low), .spi_data_out(host_sdo));
  // basic variant on the same wires: its short flags must ignore supply faults
  sdc_top #(.ENHANCED(1'b0)) dut_basic (.sys_clk(sys_clk), .sys_rst(sys_rst), .spi_clk(spi_clk),
    .spi_data_in(spi_data_in), .chip_select_low(chip_select_low), .spi_data_out(), .spi_data_oe(),
    .step_in(step_in), .dir_in(dir_in), .load_measure(load_measure),
    .current_scale_value(current_scale_value), .status_in(status_in), .diag_in(diag_in),
    .coil_out(), .microstep_position(), .step_dir_disable());

  // 40 MHz system clock
  always #12.5 sys_clk = ~sys_clk;

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // junk top nibble must be dropped; a misload would land in drive control
  task automatic set_cfg(input logic sd_dis, input logic [1:0] rsel);
    host.frame({4'h0, 3'b111, 9'h000, sd_dis, 1'b0, rsel, 4'h0}, 24, rx);
  endtask
  task automatic wr_dc(input logic [17:0] w);
    host.frame({4'hf, 2'b00, w}, 24, rx);
  endtask
  task automatic step_edge(input logic lvl, input logic [9:0] nxt);
    step_in = lvl;
    cyc(6);
    exp_pos = nxt;
    `CHK(microstep_position, exp_pos)
  endtask

  task automatic t_step();
    set_cfg(1'b0, RSEL_POSITION);
    `CHK(step_dir_disable, 1'b0)
    for (int m = 0; m <= 8; m++) begin
      wr_dc({8'h00, 1'b0, 1'b0, 4'h0, m[3:0]});
      step_edge(1'b1, exp_pos + (10'h001 << m));
      step_edge(1'b0, exp_pos);
    end
    dir_in = 1'b1;
    wr_dc({8'h00, 1'b0, 1'b1, 4'h0, 4'h8});
    step_edge(1'b1, exp_pos - 10'h100);
    step_edge(1'b0, exp_pos - 10'h100);
    dir_in = 1'b0;
    wr_dc({8'h00, 1'b1, 1'b0, 4'h0, 4'h4});
    step_in = 1'b1;
    cyc(20);
    `CHK(microstep_position == exp_pos + 10'h010, 1'b0)
    `CHK(microstep_position == exp_pos, 1'b0)
    cyc(70);
    exp_pos = exp_pos + 10'h010;
    `CHK(microstep_position, exp_pos)
    step_edge(1'b0, exp_pos);
  endtask

  task automatic t_direct();
    set_cfg(1'b1, RSEL_POSITION);
    `CHK(step_dir_disable, 1'b1)
    // magnitudes kept at or below 248
    wr_dc({1'b1, 8'hf8, 1'b0, 8'h5a});
    `CHK(coil_out, {1'b1, 8'hf8, 1'b0, 8'h5a})
    wr_dc({1'b0, 8'h01, 1'b1, 8'hf8});
    `CHK(coil_out, {1'b0, 8'h01, 1'b1, 8'hf8})
    host.frame({4'h0, 3'b101, 17'h0_0000}, 24, rx);
    `CHK(coil_out, {1'b0, 8'h01, 1'b1, 8'hf8})
    // 19 bits only: a misload would zero both coils
    host.frame(24'h00_0000, 19, rx);
    `CHK(coil_out, {1'b0, 8'h01, 1'b1, 8'hf8})
    step_edge(1'b1, exp_pos);
    step_edge(1'b0, exp_pos);
  endtask

  task automatic t_resp();
    logic [19:0] er;
    for (int s = 0; s < 4; s++) begin
      load_measure = 10'h2b5 ^ 10'(s);
      current_scale_value = 5'h13;
      // supply shorts on one coil each, so folding into the short flags shows
      status_in = s[0] ? 10'h132 : 10'h2cd;
      diag_in = 6'h2d;
      // second frame reads back with the select already in force
      set_cfg(1'b0, s[1:0]);
      set_cfg(1'b0, s[1:0]);
      case (s)
        0: er[19:8] = {exp_pos, 2'b00};
        1: er[19:8] = {load_measure, 2'b00};
        2: er[19:8] = {load_measure[9:5], current_scale_value, 2'b00};
        default: er[19:8] = {diag_in[5:4], status_in[4], status_in[6], status_in[3], status_in[5],
          diag_in[3:0], 2'b11};
      endcase
      // enhanced part: a short flag covers both ground and supply faults of its coil
      er[7:0] = {status_in[9:7], status_in[6] | status_in[4], status_in[5] | status_in[3], status_in[2:0]};
      `CHK(rx, {er, 4'h0})
      `CHK(spi_data_oe, 1'b0)
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    sys_clk = 1'b0;
    sys_rst = 1'b1;
    step_in = 1'b0;
    dir_in = 1'b0;
    load_measure = 10'h000;
    current_scale_value = 5'h00;
    status_in = '0;
    diag_in = '0;
    exp_pos = 10'h000;
    err_total = 0;
    checks_done = 0;
    repeat (4) @(posedge sys_clk);
    #1;
    sys_rst = 1'b0;
    cyc(4);
    t_step();
    t_direct();
    t_resp();
    test_done();
  end
  // watchdog against a hung run
  initial begin
    repeat (100000) @(posedge sys_clk);
    err_total++;
    test_done();
  end
endmodule
`default_nettype wire
